/* fpsu_defines.svh */
// Constants for the front-panel status and user I/O block
`ifndef FPSU_DEFINES_SVH
`define FPSU_DEFINES_SVH

`define FPSU_CLK_HZ 25000000
`define FPSU_FLASH_HZ 4
// Half period of the 4 Hz flash, in clock cycles
`define FPSU_FLASH_HALF (`FPSU_CLK_HZ / (2 * `FPSU_FLASH_HZ))
`define FPSU_BACKLIGHT_S 120
// Backlight hold counted in flash half periods (8 per second)
`define FPSU_BACKLIGHT_TICKS (`FPSU_BACKLIGHT_S * 2 * `FPSU_FLASH_HZ)

`define FPSU_ADDR_CTRL 12'h000
`define FPSU_ADDR_RELAY 12'h004
`define FPSU_ADDR_STATUS 12'h008
`define FPSU_ADDR_UI 12'h00c

// Control register fields
`define FPSU_CTRL_BUZZ_EN 0
`define FPSU_CTRL_INIT_DONE 1
`define FPSU_CTRL_RST 32'h0000_0001

// Relay config: 4 bits per relay, [1:0] source, [3:2] setting
`define FPSU_RELAY_RST 32'h0000_0000

`define FPSU_DIGITS 8
`define FPSU_SCREENS 16

`endif

/* fpsu_pkg.sv */
// Types shared by the front-panel status and user I/O block
package fpsu_pkg;
  typedef enum logic [1:0] {
    FPSU_SRC_FORCED = 2'h0,
    FPSU_SRC_ALARM = 2'h1,
    FPSU_SRC_INPUT = 2'h2
  } fpsu_src_e;

  typedef enum logic [1:0] {
    FPSU_FORCE_UNUSED = 2'h0,
    FPSU_FORCE_OPEN = 2'h1,
    FPSU_FORCE_CLOSED = 2'h2
  } fpsu_force_e;

  typedef enum logic [1:0] {
    FPSU_CLS_TX = 2'h0,
    FPSU_CLS_RX = 2'h1,
    FPSU_CLS_BOTH = 2'h2
  } fpsu_cls_e;

  typedef enum logic [2:0] {
    FPSU_UI_DISPLAY = 3'b001,
    FPSU_UI_ADJUST = 3'b010,
    FPSU_UI_POSITION = 3'b100
  } fpsu_ui_e;
endpackage

/* fpsu_flash_timebase.sv */
// Shared 4 Hz flash timebase
`timescale 1ns/100ps
`include "fpsu_defines.svh"
module fpsu_flash_timebase import fpsu_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  output logic flash, // 4 Hz square wave
  output logic half_tick // Pulse each half period
);
  localparam int unsigned HALF = `FPSU_FLASH_HALF;
  logic [22:0] cnt;

  // Equal on and off halves so every lamp flashes in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 23'h0;
      flash <= 1'b0;
      half_tick <= 1'b0;
    end else if (cnt == 23'(HALF - 1)) begin
      cnt <= 23'h0;
      flash <= ~flash;
      half_tick <= 1'b1;
    end else begin
      cnt <= cnt + 23'h1;
      half_tick <= 1'b0;
    end
  end
endmodule // fpsu_flash_timebase

/* fpsu_relay_select.sv */
// Source selection for one user relay output
`timescale 1ns/100ps
`include "fpsu_defines.svh"
module fpsu_relay_select import fpsu_pkg::*; (
  input wire logic [3:0] cfg, // [1:0] source, [3:2] setting
  input wire logic tx_alarm, // Transmit alarm active
  input wire logic rx_alarm, // Receive alarm active
  input wire logic [7:0] user_in, // Monitored user inputs
  output logic relay_open // 1: normally-open contact made
);
  always_comb begin
    relay_open = 1'b0;
    case (fpsu_src_e'(cfg[1:0]))
      FPSU_SRC_FORCED: begin
        relay_open = (fpsu_force_e'(cfg[3:2]) == FPSU_FORCE_OPEN);
      end
      FPSU_SRC_ALARM: begin
        case (fpsu_cls_e'(cfg[3:2]))
          FPSU_CLS_TX: relay_open = tx_alarm;
          FPSU_CLS_RX: relay_open = rx_alarm;
          FPSU_CLS_BOTH: relay_open = tx_alarm & rx_alarm;
          default: relay_open = 1'b0;
        endcase
      end
      FPSU_SRC_INPUT: begin
        // Setting field picks input 0, 1, 6 or 7; bit 3 adds 4 to the index
        relay_open = ~user_in[cfg[3:2] + (cfg[3] ? 3'h4 : 3'h0)];
      end
      default: relay_open = 1'b0;
    endcase
  end
endmodule // fpsu_relay_select

/* fpsu_front_panel.sv */
// Front-panel lamps, backlight, buzzer, keys and user relays with APB registers
`timescale 1ns/100ps
`include "fpsu_defines.svh"
module fpsu_front_panel import fpsu_pkg::*; (
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sys_init, // System initialising
  input wire logic severe_alarm, // Alarm that disrupts traffic
  input wire logic minor_alarm, // Alarm that leaves traffic intact
  input wire logic tx_alarm, // Transmit class alarm
  input wire logic rx_alarm, // Receive class alarm
  input wire logic far_unreachable, // No contact with far end
  input wire logic far_mux_alarm, // Far end reports mux alarm
  input wire logic self_test, // Loopback self test running
  input wire logic eth_collision, // Transport port collision
  input wire logic eth_active, // Transport port active
  input wire logic eth_link_ok, // Transport port properly connected
  input wire logic key_escape, // Escape key pressed, level
  input wire logic key_select, // Select key pressed, level
  input wire logic key_right, // Right key pressed, level
  input wire logic key_left, // Left key pressed, level
  input wire logic key_confirm, // Confirm key pressed, level
  input wire logic [7:0] user_in, // Monitored user inputs
  output logic normal_lamp, // Normal status lamp
  output logic alarm_lamp, // Alarm lamp
  output logic far_station_lamp, // Remote status lamp
  output logic test_lamp, // Self test lamp
  output logic collision_lamp, // Ethernet collision lamp
  output logic link_lamp, // Ethernet link lamp
  output logic backlight, // Display backlight
  output logic buzzer, // Alarm buzzer
  output logic [3:0] relay_open, // Relays on normally-open contact
  output logic [3:0] screen, // Current screen index
  output logic [2:0] digit, // Current edit digit
  output logic [3:0] digit_value, // Value of current digit
  output logic edit_commit // Pulse when an edit is committed
);
  // ---------------------------------------------------------------
  // Timebase and relay sources
  // ---------------------------------------------------------------
  logic flash;
  logic half_tick;
  logic [31:0] ctrl;
  logic [15:0] relay_cfg;
  logic [3:0] next_relay;

  fpsu_flash_timebase u_tb (
    .pclk(pclk),
    .presetn(presetn),
    .flash(flash),
    .half_tick(half_tick)
  );

  for (genvar g = 0; g < 4; g++) begin : g_relay
    fpsu_relay_select u_rel (
      .cfg(relay_cfg[4*g +: 4]),
      .tx_alarm(tx_alarm),
      .rx_alarm(rx_alarm),
      .user_in(user_in),
      .relay_open(next_relay[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) relay_open <= 4'h0;
    else relay_open <= next_relay;
  end

  // ---------------------------------------------------------------
  // Status lamps
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      normal_lamp <= 1'b0;
      alarm_lamp <= 1'b0;
      far_station_lamp <= 1'b0;
      test_lamp <= 1'b0;
      collision_lamp <= 1'b0;
      link_lamp <= 1'b0;
    end else begin
      if (severe_alarm) normal_lamp <= 1'b0;
      else if (sys_init) normal_lamp <= flash;
      else normal_lamp <= 1'b1;
      if (severe_alarm) alarm_lamp <= 1'b1;
      else if (minor_alarm) alarm_lamp <= flash;
      else alarm_lamp <= 1'b0;
      if (far_unreachable) far_station_lamp <= flash;
      else if (far_mux_alarm) far_station_lamp <= 1'b1;
      else far_station_lamp <= 1'b0;
      test_lamp <= self_test;
      collision_lamp <= eth_collision;
      // The shared flash keeps the link lamp in step with the others
      link_lamp <= eth_active & (eth_link_ok | flash);
    end
  end

  // this block only shows port state; no path joins the two ports.

  // ---------------------------------------------------------------
  // Key edges
  // ---------------------------------------------------------------
  logic [4:0] keys_d;
  logic [4:0] keys;
  logic [4:0] press;
  assign keys = {key_confirm, key_left, key_right, key_select, key_escape};
  assign press = keys & ~keys_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) keys_d <= 5'h0;
    else keys_d <= keys;
  end

  // ---------------------------------------------------------------
  // Backlight and buzzer
  // ---------------------------------------------------------------
  logic any_alarm;
  logic alarm_d;
  logic [10:0] bl_cnt;
  logic key_bl;
  logic [10:0] key_cnt;
  assign any_alarm = severe_alarm | minor_alarm;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_d <= 1'b0;
      bl_cnt <= 11'h0;
      key_cnt <= 11'h0;
      key_bl <= 1'b0;
      backlight <= 1'b0;
    end else begin
      alarm_d <= any_alarm;
      if (any_alarm && !alarm_d) bl_cnt <= 11'(`FPSU_BACKLIGHT_TICKS);
      else if (half_tick && bl_cnt != 11'h0) bl_cnt <= bl_cnt - 11'h1;
      // Key light uses the same hold so the panel stays readable
      if (|press) key_cnt <= 11'(`FPSU_BACKLIGHT_TICKS);
      else if (half_tick && key_cnt != 11'h0) key_cnt <= key_cnt - 11'h1;
      key_bl <= |press;
      backlight <= (bl_cnt != 11'h0) | (key_cnt != 11'h0) | key_bl;
    end
  end

  logic buzz_mute;
  fpsu_ui_e ui;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buzz_mute <= 1'b0;
      buzzer <= 1'b0;
    end else begin
      // A fresh alarm wins over a mute press in the same cycle
      if (any_alarm && !alarm_d) buzz_mute <= 1'b0;
      else if (press[1] && ui == FPSU_UI_DISPLAY) buzz_mute <= 1'b1;
      else if (!any_alarm) buzz_mute <= 1'b0;
      buzzer <= any_alarm & ctrl[`FPSU_CTRL_BUZZ_EN] & ~buzz_mute;
    end
  end

  // ---------------------------------------------------------------
  // Key interpretation
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ui <= FPSU_UI_DISPLAY;
      screen <= 4'h0;
      digit <= 3'h0;
      digit_value <= 4'h0;
      edit_commit <= 1'b0;
    end else begin
      edit_commit <= 1'b0;
      case (ui)
        FPSU_UI_DISPLAY: begin
          if (press[0]) screen <= 4'h0;
          else if (press[2]) screen <= screen + 4'h1;
          else if (press[3]) screen <= screen - 4'h1;
          else if (press[4]) begin
            ui <= FPSU_UI_POSITION;
            digit <= 3'h0;
          end
        end
        FPSU_UI_ADJUST, FPSU_UI_POSITION: begin
          if (press[0]) ui <= FPSU_UI_DISPLAY;
          else if (press[4]) begin
            ui <= FPSU_UI_DISPLAY;
            edit_commit <= 1'b1;
          end else if (press[1]) begin
            ui <= (ui == FPSU_UI_ADJUST) ? FPSU_UI_POSITION : FPSU_UI_ADJUST;
          end else if (press[2]) begin
            if (ui == FPSU_UI_ADJUST) digit_value <= digit_value + 4'h1;
            else digit <= digit + 3'h1;
          end else if (press[3]) begin
            if (ui == FPSU_UI_ADJUST) digit_value <= digit_value - 4'h1;
            else digit <= digit - 3'h1;
          end
        end
        default: ui <= FPSU_UI_DISPLAY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  logic wr;
  logic rd;
  logic mapped;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign mapped = (paddr == `FPSU_ADDR_CTRL) | (paddr == `FPSU_ADDR_RELAY) |
    (paddr == `FPSU_ADDR_STATUS) | (paddr == `FPSU_ADDR_UI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `FPSU_CTRL_RST;
      relay_cfg <= 16'h0000;
    end else if (wr) begin
      if (paddr == `FPSU_ADDR_CTRL) ctrl <= {30'h0, pwdata[1:0]};
      if (paddr == `FPSU_ADDR_RELAY) relay_cfg <= pwdata[15:0];
    end
  end

  // Zero wait states; read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd) begin
        case (paddr)
          `FPSU_ADDR_CTRL: prdata <= ctrl;
          `FPSU_ADDR_RELAY: prdata <= {16'h0, relay_cfg};
          `FPSU_ADDR_STATUS: prdata <= {8'h0, user_in, 4'h0, relay_open, buzzer,
            backlight, link_lamp, collision_lamp, test_lamp, far_station_lamp,
            alarm_lamp, normal_lamp};
          `FPSU_ADDR_UI: prdata <= {18'h0, ui, screen, digit, digit_value};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // fpsu_front_panel

/* fpsu_front_panel_chk.sv */
// Port-level checks for the front-panel block
`timescale 1ns/100ps
module fpsu_front_panel_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic sys_init, // Initialising
  input wire logic severe_alarm, // Severe alarm
  input wire logic minor_alarm, // Minor alarm
  input wire logic far_unreachable, // Far end lost
  input wire logic far_mux_alarm, // Far mux alarm
  input wire logic self_test, // Self test
  input wire logic eth_collision, // Collision
  input wire logic eth_active, // Port active
  input wire logic eth_link_ok, // Port connected
  input wire logic key_escape, // Key
  input wire logic key_select, // Key
  input wire logic key_right, // Key
  input wire logic key_left, // Key
  input wire logic key_confirm, // Key
  input wire logic normal_lamp, // Lamp
  input wire logic alarm_lamp, // Lamp
  input wire logic far_station_lamp, // Lamp
  input wire logic test_lamp, // Lamp
  input wire logic collision_lamp, // Lamp
  input wire logic link_lamp, // Lamp
  input wire logic backlight // Backlight
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // -----------------
  // Sequences
  // -----------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_key_rise;
    $rose(key_escape || key_select || key_right || key_left || key_confirm);
  endsequence
  sequence s_alarm_rise;
    $rose(severe_alarm || minor_alarm);
  endsequence
  // Reset level in the antecedent skips the edge on which reset is released
  sequence s_healthy;
    presetn && !sys_init && !severe_alarm && !minor_alarm;
  endsequence
  AST_APB_READY: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not a single access-cycle pulse");
  AST_NORMAL_ON: assert property (s_healthy |=> normal_lamp)
    else $error("normal lamp dark while healthy");
  AST_NORMAL_DARK: assert property (severe_alarm |=> !normal_lamp)
    else $error("normal lamp lit on severe alarm");
  AST_ALARM_ON: assert property (severe_alarm |=> alarm_lamp)
    else $error("alarm lamp not steady on severe alarm");
  AST_ALARM_OFF: assert property (!severe_alarm && !minor_alarm |=> !alarm_lamp)
    else $error("alarm lamp lit with no alarm");
  AST_FAR_ON: assert property (!far_unreachable && far_mux_alarm |=> far_station_lamp)
    else $error("far lamp dark on far mux alarm");
  AST_FAR_DARK: assert property (!far_unreachable && !far_mux_alarm |=> !far_station_lamp)
    else $error("far lamp lit while far end fine");
  AST_TEST_LAMP: assert property (self_test |=> test_lamp)
    else $error("test lamp dark during self test");
  AST_COLLISION: assert property (eth_collision |=> collision_lamp)
    else $error("collision lamp dark on collision");
  AST_LINK: assert property (eth_active && eth_link_ok |=> link_lamp)
    else $error("link lamp not steady on good link");
  AST_KEY_LIGHT: assert property (s_key_rise |-> ##[1:3] backlight)
    else $error("backlight not on after key press");
  AST_ALARM_LIGHT: assert property (s_alarm_rise |-> ##[1:3] backlight)
    else $error("backlight not on after alarm onset");
endmodule // fpsu_front_panel_chk

bind fpsu_front_panel fpsu_front_panel_chk chk_u (.*);

/* fpsu_panel_model.sv */
// Operator model: turns one-shot key requests into held key presses
`timescale 1ns/100ps
module fpsu_panel_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [4:0] key_req, // Press request, one bit per key
  output logic key_escape, // Key level
  output logic key_select, // Key level
  output logic key_right, // Key level
  output logic key_left, // Key level
  output logic key_confirm // Key level
);
  logic [4:0] keys;
  logic [2:0] hold_cnt;
  // A real press spans many clocks; five is enough for the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys <= 5'h00;
      hold_cnt <= 3'h0;
    end else if (key_req != 5'h00) begin
      keys <= key_req;
      hold_cnt <= 3'h4;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      keys <= 5'h00;
    end
  end
  assign {key_confirm, key_left, key_right, key_select, key_escape} = keys;
endmodule // fpsu_panel_model

/* fpsu_front_panel_tb.sv */
// Self-checking bench for the front-panel block
`timescale 1ns/100ps
`include "fpsu_defines.svh"
module fpsu_front_panel_tb import fpsu_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sys_init = 1'b1, severe_alarm = 1'b0, minor_alarm = 1'b0;
  logic tx_alarm = 1'b0, rx_alarm = 1'b0, far_unreachable = 1'b0, far_mux_alarm = 1'b0;
  logic self_test = 1'b0, eth_collision = 1'b0, eth_active = 1'b0, eth_link_ok = 1'b0;
  logic key_escape, key_select, key_right, key_left, key_confirm;
  logic [4:0] key_req = 5'h00;
  logic [7:0] user_in = 8'hfe;
  logic normal_lamp, alarm_lamp, far_station_lamp, test_lamp, collision_lamp, link_lamp;
  logic backlight, buzzer, edit_commit;
  logic [3:0] relay_open, screen, digit_value;
  logic [2:0] digit;
  int fail_count = 0, check_count = 0, commit_seen = 0;
  // Relay table, entry i in nibble i (expected in bit i): config, {tx,rx,input0}, expected
  localparam logic [39:0] NIB_T = 40'h2259951840;
  localparam logic [39:0] CTL_T = 40'h5426444444;
  localparam logic [9:0] EXP_T = 10'b0111001010;
  fpsu_front_panel dut_u (.*);
  fpsu_panel_model model_u (.*);
  always #20 pclk = ~pclk;
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for pready with no assumed latency; the watchdog cuts a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never re-raises psel in the same step
    @(posedge pclk);
  endtask
  task automatic press(input logic [4:0] k);
    key_req <= k;
    @(posedge pclk);
    key_req <= 5'h00;
    repeat (12) begin
      @(posedge pclk);
      if (edit_commit === 1'b1) commit_seen++;
    end
  endtask
  task automatic ui(input logic [2:0] m, input logic [3:0] s, input logic [2:0] d,
                    input logic [3:0] v);
    apb(1'b0, `FPSU_ADDR_UI, 32'h0);
    chk("ui", {18'h0, m, s, d, v}, rd);
    chk("digit port", {25'h0, d, v}, {25'h0, digit, digit_value});
  endtask
  task automatic lamp(input logic [4:0] c, input logic [3:0] e);
    {severe_alarm, minor_alarm, far_unreachable, far_mux_alarm, self_test} <= c;
    step(3);
    chk("lamps", {28'h0, e}, {28'h0, normal_lamp, alarm_lamp, far_station_lamp, test_lamp});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    step(8);
    presetn <= 1'b1;
    chk("backlight idle", 32'h0, {31'h0, backlight});
    apb(1'b0, `FPSU_ADDR_CTRL, 32'h0);
    chk("ctrl", `FPSU_CTRL_RST, rd);
    apb(1'b0, `FPSU_ADDR_RELAY, 32'h0);
    chk("relay cfg", `FPSU_RELAY_RST, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `FPSU_ADDR_CTRL, 32'h3);
    apb(1'b1, 12'h010, 32'h0);
    chk("unmapped wr err", 32'h1, {31'h0, er});
    apb(1'b0, `FPSU_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h3, rd);
    $display("test registers done");
    lamp(5'h00, 4'h0);
    sys_init <= 1'b0;
    lamp(5'h00, 4'h8);
    lamp(5'h10, 4'h4);
    lamp(5'h08, 4'h8);
    lamp(5'h02, 4'ha);
    lamp(5'h06, 4'h8);
    lamp(5'h01, 4'h9);
    {eth_collision, eth_active, eth_link_ok} <= 3'b111;
    step(3);
    chk("collision", 32'h1, {31'h0, collision_lamp});
    chk("link", 32'h1, {31'h0, link_lamp});
    {eth_collision, eth_active, eth_link_ok} <= 3'b010;
    lamp(5'h00, 4'h8);
    chk("link bad", 32'h0, {31'h0, link_lamp});
    $display("test lamps done");
    lamp(5'h10, 4'h4);
    chk("buzzer", 32'h1, {31'h0, buzzer});
    chk("backlight", 32'h1, {31'h0, backlight});
    press(5'h02);
    chk("buzzer muted", 32'h0, {31'h0, buzzer});
    lamp(5'h00, 4'h8);
    lamp(5'h10, 4'h4);
    chk("buzzer again", 32'h1, {31'h0, buzzer});
    lamp(5'h00, 4'h8);
    $display("test buzzer done");
    // Mid-run reset clears the alarm backlight hold so the key light can be seen
    presetn <= 1'b0;
    step(2);
    presetn <= 1'b1;
    chk("backlight reset", 32'h0, {31'h0, backlight});
    press(5'h04);
    chk("screen", 32'h1, {28'h0, screen});
    chk("key backlight", 32'h1, {31'h0, backlight});
    press(5'h04);
    press(5'h08);
    ui(FPSU_UI_DISPLAY, 4'h1, 3'h0, 4'h0);
    press(5'h01);
    ui(FPSU_UI_DISPLAY, 4'h0, 3'h0, 4'h0);
    press(5'h10);
    ui(FPSU_UI_POSITION, 4'h0, 3'h0, 4'h0);
    press(5'h04);
    ui(FPSU_UI_POSITION, 4'h0, 3'h1, 4'h0);
    press(5'h08);
    press(5'h02);
    ui(FPSU_UI_ADJUST, 4'h0, 3'h0, 4'h0);
    press(5'h04);
    press(5'h04);
    press(5'h08);
    ui(FPSU_UI_ADJUST, 4'h0, 3'h0, 4'h1);
    press(5'h08);
    press(5'h02);
    ui(FPSU_UI_POSITION, 4'h0, 3'h0, 4'h0);
    press(5'h01);
    ui(FPSU_UI_DISPLAY, 4'h0, 3'h0, 4'h0);
    commit_seen = 0;
    press(5'h10);
    press(5'h10);
    chk("commits", 32'h1, commit_seen);
    ui(FPSU_UI_DISPLAY, 4'h0, 3'h0, 4'h0);
    $display("test keys done");
    for (int i = 0; i < 10; i++) begin
      {tx_alarm, rx_alarm, user_in[0]} <= CTL_T[4*i+:3];
      apb(1'b1, `FPSU_ADDR_RELAY, {16'h0, {4{NIB_T[4*i+:4]}}});
      step(3);
      chk("relay_open", {28'h0, {4{EXP_T[i]}}}, {28'h0, relay_open});
    end
    apb(1'b0, `FPSU_ADDR_STATUS, 32'h0);
    chk("status", 32'h00ff0041, rd);
    $display("test relays done");
    summarize();
  end
  initial begin
    step(6000);
    fail_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule // fpsu_front_panel_tb
